// ===== pkg/uipc_map.vh
`ifndef UIPC_MAP_VH
`define UIPC_MAP_VH
// =====================================================================
// pipe numbering
`define UIPC_FIRST_PIPE    4'h6
`define UIPC_LAST_PIPE     4'h9
`define UIPC_NPIPE         4
// =====================================================================
// control stage field codes
`define UIPC_STG_IDLE      3'h0
`define UIPC_STG_RDDATA    3'h1
`define UIPC_STG_RDSTAT    3'h2
`define UIPC_STG_WRDATA    3'h3
`define UIPC_STG_WRSTAT    3'h4
`define UIPC_STG_WRNDSTAT  3'h5
`define UIPC_STG_SEQERR    3'h6
// =====================================================================
// packet ids seen and sent on the link
`define UIPC_PID_NONE      4'h0
`define UIPC_PID_OUT       4'h1
`define UIPC_PID_IN        4'h9
`define UIPC_PID_SETUP     4'hD
`define UIPC_PID_PING      4'h4
`define UIPC_PID_ACK       4'h2
`define UIPC_PID_NAK       4'hA
`define UIPC_PID_STALL     4'hE
`define UIPC_PID_NYET      4'h6
// =====================================================================
// interval field and counter widths
`define UIPC_ITV_W         3
`define UIPC_CNT_W         8
// =====================================================================
// fifo
`define UIPC_FIFO_W        8
`define UIPC_FIFO_D        8
`define UIPC_FIFO_AW       3
`endif

// ===== hw/uipc_fifo.v
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// small flop fifo with valid/ready on both sides
module uipc_fifo #(
   parameter W  = 8,
   parameter D  = 8,
   parameter AW = 3
) (
   input  wire         mclk,     // clock
   input  wire         nrst,     // async reset, low
   input  wire         clr,      // flush contents
   input  wire [W-1:0] in_data,  // write data
   input  wire         in_valid, // write request
   output wire         in_ready, // not full
   output wire [W-1:0] out_data, // head word
   output wire         out_valid,// not empty
   input  wire         out_ready,// head taken
   output wire         empty     // fifo empty
);
   reg [W-1:0]  mem_q [0:D-1];
   reg [AW-1:0] wp_q;
   reg [AW-1:0] rp_q;
   reg [AW:0]   cnt_q;
   wire         wr;
   wire         rd;
   integer      i;
   // fill level at which writes stop, sized to the counter
   localparam [AW:0] FULL = D;

   assign in_ready  = (cnt_q != FULL);
   assign out_valid = (cnt_q != {(AW+1){1'b0}});
   assign empty     = ~out_valid;
   assign out_data  = mem_q[rp_q];
   assign wr        = in_valid & in_ready;
   assign rd        = out_valid & out_ready;

   // pointers and fill level; clr wins so a flush leaves it empty
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         wp_q  <= {AW{1'b0}};
         rp_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else if (clr) begin
         wp_q  <= {AW{1'b0}};
         rp_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (wr)
            wp_q <= wp_q + 1'b1;
         if (rd)
            rp_q <= rp_q + 1'b1;
         if (wr & ~rd)
            cnt_q <= cnt_q + 1'b1;
         else if (rd & ~wr)
            cnt_q <= cnt_q - 1'b1;
      end
   end

   // storage
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         for (i = 0; i < D; i = i + 1)
            mem_q[i] <= {W{1'b0}};
      end else if (wr) begin
         mem_q[wp_q] <= in_data;
      end
   end
endmodule // uipc_fifo
`default_nettype wire

// ===== hw/uipc_itv.v
`timescale 1ns/1ps
`default_nettype none
`include "uipc_map.vh"
// =====================================================================
// per-pipe interval timer for host-role interrupt tokens
module uipc_itv (
   input  wire                   mclk,    // clock
   input  wire                   nrst,    // async reset, low
   input  wire [`UIPC_ITV_W-1:0] itv,     // interval field, 2**itv frames
   input  wire                   aclr,    // buffer auto-clear bit
   input  wire                   run,     // bus activity enable bit
   input  wire                   frame,   // frame start pulse
   input  wire                   taken,   // token issued this cycle
   output reg                    due_q    // interval elapsed, token owed
);
   reg  [`UIPC_CNT_W-1:0] cnt_q;
   wire [`UIPC_CNT_W-1:0] reload;

   assign reload = ({{(`UIPC_CNT_W-1){1'b0}}, 1'b1} << itv) - 1'b1;

   // auto-clear reloads the count and drops a pending token; bus reset/suspend just freeze it
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= {`UIPC_CNT_W{1'b0}};
         due_q <= 1'b0;
      end else if (aclr) begin
         cnt_q <= reload;
         due_q <= 1'b0;
      end else begin
         if (run && frame) begin
            if (cnt_q == {`UIPC_CNT_W{1'b0}}) begin
               cnt_q <= reload;
               due_q <= 1'b1;
            end else begin
               cnt_q <= cnt_q - 1'b1;
            end
         end
         // one transaction per interval, no high-bandwidth extras
         if (taken && !(run && frame && cnt_q == {`UIPC_CNT_W{1'b0}}))
            due_q <= 1'b0;
      end
   end
endmodule // uipc_itv
`default_nettype wire

// ===== hw/uipc_top.v
`timescale 1ns/1ps
`default_nettype none
`include "uipc_map.vh"
module uipc_top (
   input  wire                     mclk,          // 250 mhz clock
   input  wire                     nrst,          // async reset, low
   // role and bus state
   input  wire                     host_mode,     // 1 host, 0 function
   input  wire                     bus_act,       // bus activity enable bit
   input  wire                     frame_sof,     // frame start pulse
   // per-pipe configuration, pipes 6..9 packed low to high
   input  wire [4*`UIPC_ITV_W-1:0] itv_set,       // interval field per pipe
   input  wire [3:0]               itv_wr,        // load interval field
   input  wire [3:0]               auto_clr,      // buffer auto-clear bits
   input  wire [3:0]               pipe_dir_out,  // 1: out direction
   input  wire [3:0]               pipe_stall,    // answer stall
   input  wire [3:0]               pipe_rdy,      // buffer ready to answer
   // control transfer stage source
   input  wire [2:0]               ctl_stage,     // control stage field
   input  wire                     ctl_seq_err,   // sequence error pulse
   // received token / error indications
   input  wire                     rx_tok,        // token received pulse
   input  wire [3:0]               rx_pid,        // received pid
   input  wire [3:0]               rx_ep_pipe,    // addressed pipe number
   input  wire [3:0]               mps_err,       // max packet error pulses
   // transmit data path
   input  wire [`UIPC_FIFO_W-1:0]  tx_data,       // data into fifo
   input  wire                     tx_valid,      // data valid
   output wire                     tx_ready,      // fifo accepts
   input  wire [3:0]               tx_sel,        // pipe owning the fifo
   output wire [`UIPC_FIFO_W-1:0]  link_data,     // data to link
   output wire                     link_valid,    // link data valid
   input  wire                     link_ready,    // link takes byte
   // handshake / token output
   output reg  [3:0]               hs_pid_q,      // handshake or token pid
   output reg  [3:0]               hs_pipe_q,     // pipe for hs_pid_q
   output reg                      hs_stb_q,      // one-cycle strobe
   input  wire                     tok_done,      // host transaction done
   // interrupt status and enables
   input  wire                     stg_ie,        // stage interrupt enable
   input  wire                     bemp_ie,       // buffer-empty enable
   input  wire                     stg_clr,       // clear stage status
   input  wire [3:0]               bemp_clr,      // clear empty bits
   output reg                      stg_sts_q,     // stage status
   output reg  [3:0]               bemp_sts_q,    // buffer empty status
   output wire                     irq            // interrupt output
);
   // ==================================================================
   // helpers
   function is_int_pipe;
      input [3:0] p;
      begin
         is_int_pipe = (p >= `UIPC_FIRST_PIPE) && (p <= `UIPC_LAST_PIPE);
      end
   endfunction

   function [1:0] pipe_idx;
      input [3:0] p;
      reg   [3:0] t;
      begin
         t        = p - `UIPC_FIRST_PIPE;
         pipe_idx = t[1:0];
      end
   endfunction

   // ==================================================================
   // interval fields, cleared only by power-on reset
   reg  [4*`UIPC_ITV_W-1:0] itv_q;
   wire [3:0]               due;
   reg  [3:0]               taken;
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_pipe
         always @(posedge mclk or negedge nrst) begin
            if (!nrst)
               itv_q[g*`UIPC_ITV_W +: `UIPC_ITV_W] <= {`UIPC_ITV_W{1'b0}};
            else if (itv_wr[g])
               itv_q[g*`UIPC_ITV_W +: `UIPC_ITV_W] <=
                  itv_set[g*`UIPC_ITV_W +: `UIPC_ITV_W];
         end
         // frozen outside host role so function role never self-polls
         uipc_itv u_itv (
            .mclk  (mclk),
            .nrst  (nrst),
            .itv   (itv_q[g*`UIPC_ITV_W +: `UIPC_ITV_W]),
            .aclr  (auto_clr[g]),
            .run   (bus_act & host_mode),
            .frame (frame_sof),
            .taken (taken[g]),
            .due_q (due[g])
         );
      end
   endgenerate

   // ==================================================================
   // transmit fifo; empty plus a finished pipe marks buffer-empty
   wire fifo_empty;
   wire [3:0] fifo_clr_sel;
   wire fifo_clr;
   reg  [3:0] owner_q;
   reg        sending_q;

   assign fifo_clr_sel = auto_clr;
   assign fifo_clr     = is_int_pipe(owner_q) &
                         fifo_clr_sel[pipe_idx(owner_q)];

   uipc_fifo #(
      .W  (`UIPC_FIFO_W),
      .D  (`UIPC_FIFO_D),
      .AW (`UIPC_FIFO_AW)
   ) u_fifo (
      .mclk      (mclk),
      .nrst      (nrst),
      .clr       (fifo_clr),
      .in_data   (tx_data),
      .in_valid  (tx_valid),
      .in_ready  (tx_ready),
      .out_data  (link_data),
      .out_valid (link_valid),
      .out_ready (link_ready),
      .empty     (fifo_empty)
   );

   // track which pipe has data in flight
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         owner_q   <= 4'h0;
         sending_q <= 1'b0;
      end else begin
         if (tx_valid & tx_ready) begin
            owner_q   <= tx_sel;
            sending_q <= 1'b1;
         end else if (fifo_empty) begin
            sending_q <= 1'b0;
         end
      end
   end

   wire       buf_done = sending_q & fifo_empty & is_int_pipe(owner_q);
   wire [3:0] bemp_set;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_bemp
         // pipe index as a 2-bit constant for the owner compare
         localparam [1:0] GI = g;
         assign bemp_set[g] =
            (buf_done && pipe_idx(owner_q) == GI)
            | mps_err[g];
      end
   endgenerate

   // ==================================================================
   // stage transition detect in function role
   reg  [2:0] stage_q;
   wire       stg_evt;
   always @(posedge mclk or negedge nrst) begin
      if (!nrst)
         stage_q <= `UIPC_STG_IDLE;
      else
         stage_q <= ctl_stage;
   end
   assign stg_evt = ~host_mode &
                    ((ctl_stage != stage_q)
                     | ctl_seq_err);

   // ==================================================================
   // sticky status; set wins over a same-cycle clear
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         stg_sts_q  <= 1'b0;
         bemp_sts_q <= 4'h0;
      end else begin
         stg_sts_q  <= stg_evt | (stg_sts_q & ~stg_clr);
         bemp_sts_q <= bemp_set | (bemp_sts_q & ~bemp_clr);
      end
   end

   assign irq = (stg_sts_q & stg_ie) |
                ((|bemp_sts_q) & bemp_ie);

   // ==================================================================
   // function role answer to received tokens
   wire       rx_int = rx_tok & ~host_mode & is_int_pipe(rx_ep_pipe);
   wire [1:0] rx_i   = pipe_idx(rx_ep_pipe);
   reg  [3:0] ans_pid;
   always @* begin
      if (pipe_stall[rx_i])
         ans_pid = `UIPC_PID_STALL;
      else if (pipe_rdy[rx_i])
         ans_pid = `UIPC_PID_ACK;
      else
         ans_pid = `UIPC_PID_NAK;
   end

   // ==================================================================
   // host role token scheduler, lowest due pipe first
   localparam H_IDLE = 1'b0;
   localparam H_BUSY = 1'b1;
   reg        hst_q;
   reg  [1:0] cur_q;
   reg        pick_v;
   reg  [1:0] pick;
   integer    k;
   always @* begin
      pick_v = 1'b0;
      pick   = 2'd0;
      for (k = 3; k >= 0; k = k - 1) begin
         if (due[k]) begin
            pick_v = 1'b1;
            pick   = k[1:0];
         end
      end
   end

   always @* begin
      taken = 4'h0;
      if (host_mode && bus_act && hst_q == H_IDLE && pick_v)
         taken[pick] = 1'b1;
   end

   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         hst_q     <= H_IDLE;
         cur_q     <= 2'd0;
         hs_pid_q  <= `UIPC_PID_NONE;
         hs_pipe_q <= 4'h0;
         hs_stb_q  <= 1'b0;
      end else begin
         hs_stb_q <= 1'b0;
         case (hst_q)
            H_IDLE: begin
               if (|taken) begin
                  hst_q     <= H_BUSY;
                  cur_q     <= pick;
                  hs_stb_q  <= 1'b1;
                  hs_pipe_q <= `UIPC_FIRST_PIPE + {2'b00, pick};
                  hs_pid_q  <= pipe_dir_out[pick] ?
                               `UIPC_PID_OUT :
                               `UIPC_PID_IN;
               end else if (rx_int) begin
                  if (rx_pid != `UIPC_PID_PING) begin
                     hs_stb_q  <= 1'b1;
                     hs_pipe_q <= rx_ep_pipe;
                     hs_pid_q  <= ans_pid;
                  end
               end
            end
            H_BUSY: begin
               if (tok_done || !host_mode)
                  hst_q <= H_IDLE;
            end
            default: hst_q <= H_IDLE;
         endcase
      end
   end
endmodule // uipc_top
`default_nettype wire

// ===== dv/uipc_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "uipc_map.vh"
// =====================================================================
// port checker
module uipc_chk (
   input wire logic       mclk,         // clock
   input wire logic       nrst,         // reset, low
   input wire logic       host_mode,    // role
   input wire logic [2:0] ctl_stage,    // stage field
   input wire logic       ctl_seq_err,  // sequence error
   input wire logic       rx_tok,       // token in
   input wire logic [3:0] rx_pid,       // token pid
   input wire logic [3:0] rx_ep_pipe,   // token pipe
   input wire logic [3:0] mps_err,      // size errors
   input wire logic [3:0] pipe_dir_out, // direction
   input wire logic       tok_done,     // transfer done
   input wire logic       stg_ie,       // stage enable
   input wire logic       bemp_ie,      // empty enable
   input wire logic       stg_clr,      // stage clear
   input wire logic [3:0] hs_pid_q,     // pid out
   input wire logic [3:0] hs_pipe_q,    // pipe out
   input wire logic       hs_stb_q,     // strobe out
   input wire logic       stg_sts_q,    // stage status
   input wire logic [3:0] bemp_sts_q,   // empty status
   input wire logic       irq           // interrupt
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   // pipe 6..9 folds onto bit 0..3 by wrapping the low bits
   wire [1:0] pix = hs_pipe_q[1:0] + 2'h2;
   wire fn_tok = rx_tok && !host_mode && rx_ep_pipe >= 4'h6
                 && rx_ep_pipe <= 4'h9;
   property p_stg; $changed(ctl_stage) && !host_mode |=> stg_sts_q;
   endproperty
   property p_seq; ctl_seq_err && !host_mode |=> stg_sts_q; endproperty
   property p_irq;
      irq == ((stg_sts_q && stg_ie) || ((|bemp_sts_q) && bemp_ie));
   endproperty
   property p_hold; stg_sts_q && !stg_clr |=> stg_sts_q; endproperty
   property p_mps;
      |mps_err |=> (bemp_sts_q & $past(mps_err)) == $past(mps_err);
   endproperty
   property p_ping; fn_tok && rx_pid == `UIPC_PID_PING |=> !hs_stb_q;
   endproperty
   property p_nyet; hs_stb_q |-> hs_pid_q != `UIPC_PID_NYET; endproperty
   property p_ans;
      fn_tok && rx_pid != `UIPC_PID_PING
      |=> hs_stb_q && hs_pipe_q == $past(rx_ep_pipe);
   endproperty
   property p_dir;
      host_mode && hs_stb_q |-> hs_pid_q ==
         (pipe_dir_out[pix] ? `UIPC_PID_OUT : `UIPC_PID_IN);
   endproperty
   property p_busy;
      host_mode && hs_stb_q ##1 !tok_done [*2] |=> !hs_stb_q;
   endproperty
   a_stg: assert property (p_stg)
      else $error("stage change not flagged");
   a_seq: assert property (p_seq)
      else $error("sequence error not flagged");
   a_irq: assert property (p_irq)
      else $error("interrupt level wrong");
   a_hold: assert property (p_hold)
      else $error("stage status dropped");
   a_mps: assert property (p_mps)
      else $error("size error not flagged");
   a_ping: assert property (p_ping)
      else $error("ping answered");
   a_nyet: assert property (p_nyet)
      else $error("nyet sent");
   a_ans: assert property (p_ans)
      else $error("token not answered");
   a_dir: assert property (p_dir)
      else $error("token pid wrong");
   a_busy: assert property (p_busy)
      else $error("second token while busy");
   c_stg: cover property (!host_mode && $changed(ctl_stage));
   c_ping: cover property (fn_tok && rx_pid == `UIPC_PID_PING);
   c_host: cover property (host_mode && hs_stb_q);
endmodule // uipc_chk
bind uipc_top uipc_chk chk_u (
   .mclk, .nrst, .host_mode, .ctl_stage, .ctl_seq_err, .rx_tok, .rx_pid,
   .rx_ep_pipe, .mps_err, .pipe_dir_out, .tok_done, .stg_ie, .bemp_ie,
   .stg_clr, .hs_pid_q, .hs_pipe_q, .hs_stb_q, .stg_sts_q, .bemp_sts_q,
   .irq
);
`default_nettype wire

// ===== dv/uipc_peer.sv
`timescale 1ns/1ps
`default_nettype none
`include "uipc_map.vh"
// =====================================================================
// far-side model: token source, byte sink, transfer completion
module uipc_peer (
   input  wire logic       mclk,       // clock
   input  wire logic       hs_stb_q,   // strobe
   input  wire logic [3:0] hs_pid_q,   // pid
   input  wire logic [3:0] hs_pipe_q,  // pipe
   input  wire logic [7:0] link_data,  // byte
   input  wire logic       link_valid, // byte valid
   output logic            link_ready, // byte taken
   output logic            rx_tok,     // token pulse
   output logic [3:0]      rx_pid,     // token pid
   output logic [3:0]      rx_ep_pipe, // token pipe
   output logic            tok_done    // transfer done
);
   logic       stall = 1'b1; // bench holds the sink off
   logic       slow  = 1'b0; // take a byte every other cycle
   logic       tog   = 1'b0;
   logic [1:0] lat   = 2'h0;
   int         cnt [4];
   int         outs  = 0;
   logic [7:0] got [$];
   initial begin
      rx_tok = 1'b0;
      rx_pid = 4'h0;
      rx_ep_pipe = 4'h0;
   end
   // one token; lines show the inverse once released, not stale values
   task automatic send_tok(input logic [3:0] pid, input logic [3:0] pipe);
      @(negedge mclk);
      rx_tok = 1'b1;
      rx_pid = pid;
      rx_ep_pipe = pipe;
      @(negedge mclk);
      rx_tok = 1'b0;
      rx_pid = ~pid;
      rx_ep_pipe = ~pipe;
   endtask
   // sink and completion, three cycles late to hold the device busy
   always @(negedge mclk) begin
      tog <= ~tog;
      if (!stall && (!slow || tog) && link_valid) got.push_back(link_data);
      link_ready <= !stall && (!slow || tog);
      tok_done <= (lat == 2'h1);
      if (hs_stb_q) begin
         cnt[2'(hs_pipe_q[1:0] + 2'h2)]++;
         outs += (hs_pid_q == `UIPC_PID_OUT);
         lat <= 2'h3;
      end else if (lat != 2'h0) begin
         lat <= lat - 2'h1;
      end
   end
endmodule // uipc_peer
`default_nettype wire

// ===== dv/tb_usb_interrupt_pipe_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "uipc_map.vh"
module tb_usb_interrupt_pipe_control;
   logic        mclk, nrst, host_mode, bus_act, frame_sof, ctl_seq_err;
   logic        tx_valid, stg_ie, bemp_ie, stg_clr;
   logic [11:0] itv_set;
   logic [3:0]  itv_wr, auto_clr, pipe_dir_out, pipe_stall, pipe_rdy;
   logic [3:0]  mps_err, tx_sel, bemp_clr;
   logic [2:0]  ctl_stage;
   logic [7:0]  tx_data;
   wire  [7:0]  link_data;
   wire  [3:0]  hs_pid_q, hs_pipe_q, bemp_sts_q, rx_pid, rx_ep_pipe;
   wire         tx_ready, link_valid, link_ready, hs_stb_q, stg_sts_q, irq;
   wire         rx_tok, tok_done;
   int          errors = 0;
   int          checks_done = 0;
   uipc_top dut_u (.mclk, .nrst, .host_mode, .bus_act, .frame_sof,
      .itv_set, .itv_wr, .auto_clr, .pipe_dir_out, .pipe_stall, .pipe_rdy,
      .ctl_stage, .ctl_seq_err, .rx_tok, .rx_pid, .rx_ep_pipe, .mps_err,
      .tx_data, .tx_valid, .tx_ready, .tx_sel, .link_data, .link_valid,
      .link_ready, .hs_pid_q, .hs_pipe_q, .hs_stb_q, .tok_done, .stg_ie,
      .bemp_ie, .stg_clr, .bemp_clr, .stg_sts_q, .bemp_sts_q, .irq);
   uipc_peer peer_u (.mclk, .hs_stb_q, .hs_pid_q, .hs_pipe_q, .link_data,
      .link_valid, .link_ready, .rx_tok, .rx_pid, .rx_ep_pipe, .tok_done);
   // =====================================================================
   // shared tasks
   task automatic chk(input string what, input logic [7:0] seen,
                      input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   // =====================================================================
   // main sequence
   initial begin
      {nrst, host_mode, bus_act, frame_sof, ctl_seq_err} = 5'h00;
      {tx_valid, stg_ie, bemp_ie, stg_clr} = 4'h0;
      {itv_set, itv_wr, auto_clr, pipe_dir_out} = 24'h000000;
      {pipe_stall, pipe_rdy, mps_err, tx_sel, bemp_clr} = 20'h00000;
      ctl_stage = 3'h0;
      tx_data = 8'h00;
      cyc(4);
      nrst = 1'b1;
      chk("reset status", {stg_sts_q, bemp_sts_q, irq}, 8'h00);
      // stage codes 1 to 5, then a sequence error; enable alternates
      for (int i = 1; i <= 6; i++) begin
         stg_ie = i[0];
         if (i == 6) ctl_seq_err = 1'b1;
         else ctl_stage = i[2:0];
         cyc(1);
         ctl_seq_err = 1'b0;
         chk("stage status", stg_sts_q, 8'h01);
         chk("stage irq", irq, {7'h00, i[0]});
         stg_clr = 1'b1;
         cyc(1);
         stg_clr = 1'b0;
         chk("stage cleared", stg_sts_q, 8'h00);
      end
      // stage moves in host role raise nothing
      host_mode = 1'b1;
      ctl_stage = 3'h0;
      cyc(2);
      chk("host stage", stg_sts_q, 8'h00);
      host_mode = 1'b0;
      // function answers: stall, ack, ack, nak; pings and pipe 5 silent
      pipe_stall = 4'h1;
      pipe_rdy = 4'h6;
      for (int g = 0; g < 4; g++) begin
         peer_u.send_tok(`UIPC_PID_OUT, 4'(6 + g));
         chk("fn strobe", hs_stb_q, 8'h01);
         chk("fn pipe", hs_pipe_q, 8'(6 + g));
         chk("fn pid", hs_pid_q, g == 0 ? `UIPC_PID_STALL : g < 3 ?
             `UIPC_PID_ACK : `UIPC_PID_NAK);
         peer_u.send_tok(`UIPC_PID_PING, 4'(6 + g));
         chk("ping ignored", hs_stb_q, 8'h00);
      end
      peer_u.send_tok(`UIPC_PID_IN, 4'h5);
      chk("stray pipe", hs_stb_q, 8'h00);
      // size errors on pipes 7 and 9
      bemp_ie = 1'b1;
      mps_err = 4'hA;
      cyc(1);
      mps_err = 4'h0;
      chk("size error", bemp_sts_q, 8'h0A);
      chk("empty irq", irq, 8'h01);
      bemp_clr = 4'hF;
      cyc(1);
      bemp_clr = 4'h0;
      chk("empty cleared", {bemp_sts_q, irq}, 8'h00);
      // fill for pipe 8 against a stalled sink, then drain slowly
      tx_sel = 4'h8;
      tx_valid = 1'b1;
      for (int i = 0; i < 8; i++) begin
         tx_data = 8'h30 + 8'(i);
         chk("fifo room", tx_ready, 8'h01);
         cyc(1);
      end
      tx_valid = 1'b0;
      chk("fifo full", tx_ready, 8'h00);
      cyc(4);
      chk("early empty", bemp_sts_q, 8'h00);
      peer_u.slow = 1'b1;
      peer_u.stall = 1'b0;
      for (int i = 0; i < 60 && bemp_sts_q !== 4'h4; i++) cyc(1);
      if (bemp_sts_q !== 4'h4) begin
         errors++;
         end_of_test();
      end
      chk("drained empty", bemp_sts_q, 8'h04);
      chk("drain count", 8'(peer_u.got.size()), 8'h08);
      foreach (peer_u.got[i])
         chk("drain byte", peer_u.got[i], 8'h30 + 8'(i));
      bemp_clr = 4'hF;
      cyc(1);
      bemp_clr = 4'h0;
      // host role: intervals 1,2,4,8 frames, eight live frames, 3 frozen
      host_mode = 1'b1;
      pipe_dir_out = 4'h5;
      itv_set = {3'h3, 3'h2, 3'h1, 3'h0};
      itv_wr = 4'hF;
      auto_clr = 4'hF;
      cyc(1);
      itv_wr = 4'h0;
      cyc(1);
      auto_clr = 4'h0;
      peer_u.cnt = '{default: 0};
      peer_u.outs = 0;
      for (int f = 0; f < 11; f++) begin
         bus_act = !(f >= 4 && f < 7);
         frame_sof = 1'b1;
         cyc(1);
         frame_sof = 1'b0;
         cyc(40);
      end
      foreach (peer_u.cnt[g]) chk("pipe tokens", 8'(peer_u.cnt[g]),
         8'(8 >> g));
      chk("out tokens", 8'(peer_u.outs), 8'h0A);
      end_of_test();
   end
endmodule // tb_usb_interrupt_pipe_control
`default_nettype wire
